// ==== src/dcps_pkg.sv ====
// Purpose: shared constants of the dual card power sequencer
// Assumes: core clock of 50 MHz
// Notes: times kept in microseconds, counts derived from them

package dcps_pkg;

  // ==========================================================
  // timing
  localparam int unsigned CLK_MHZ = 50;
  localparam int unsigned T_RELEASE_US = 800;
  localparam int unsigned T_FORCE_US = 8;
  localparam int unsigned RELEASE_CYCLES = T_RELEASE_US * CLK_MHZ;
  localparam int unsigned FORCE_CYCLES = T_FORCE_US * CLK_MHZ;
  localparam int unsigned TIMER_W = 16;

  // ==========================================================
  // host clock edges counted in activation and deactivation
  localparam logic [1:0] CLK_EDGES_ON = 2'h2;
  localparam logic [1:0] CLK_EDGES_OFF = 2'h2;

  // ==========================================================
  // data line bridge: cycles ignored after a release
  localparam logic [1:0] IO_GUARD_CYCLES = 2'h3;

  // ==========================================================
  // synchroniser input positions
  localparam int unsigned SYNC_W = 11;
  localparam int unsigned SI_ENABLE = 0;
  localparam int unsigned SI_CARD_SEL = 1;
  localparam int unsigned SI_VOLT_SEL = 2;
  localparam int unsigned SI_SUPPLY_OK = 3;
  localparam int unsigned SI_HOST_RST = 4;
  localparam int unsigned SI_HOST_CLK = 5;
  localparam int unsigned SI_HOST_IO = 6;
  localparam int unsigned SI_CARD_IO = 7;
  localparam int unsigned SI_CARD_GOOD = 9;

  // ==========================================================
  // sequencer states and data line bridge states
  typedef enum logic [2:0] {
    SEQ_OFF = 3'b000,
    SEQ_RAMP = 3'b001,
    SEQ_HOLD = 3'b010,
    SEQ_CLK_WAIT = 3'b011,
    SEQ_ACTIVE = 3'b100,
    SEQ_DEACT = 3'b101
  } dcps_seq_t;

  typedef enum logic [1:0] {
    IO_IDLE = 2'b00,
    IO_HOST_LOW = 2'b01,
    IO_CARD_LOW = 2'b10,
    IO_GUARD = 2'b11
  } dcps_io_t;

endpackage

// ==== src/dcps_sync.sv ====
// Purpose: two flop synchroniser for pin inputs
// Assumes: inputs are slow levels relative to the clock
// Notes: only the second stage is visible outside
`timescale 1ns/1ns
`default_nettype none

module dcps_sync #(
  parameter int unsigned WIDTH = 1
) (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // data
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  always_ff @(posedge clock) begin
    if (reset) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;

endmodule

`default_nettype wire

// ==== src/dcps_io_path.sv ====
// Purpose: open drain data line bridge between host and selected card
// Assumes: both inputs already synchronised, lines idle high by pull-ups
// Notes: the side that pulls low first owns the line until it lets go
`timescale 1ns/1ns
`default_nettype none

module dcps_io_path (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // control
  input wire logic pass_enable,
  input wire logic force_low,
  // line levels
  input wire logic host_in,
  input wire logic card_in,
  // pull-down requests
  output logic host_pull_low,
  output logic card_pull_low
);

  dcps_pkg::dcps_io_t st_q, st_d;
  logic [1:0] guard_q, guard_d;
  logic host_pull_q, host_pull_d;
  logic card_pull_q, card_pull_d;

  // ==========================================================
  // ownership of the line
  always_comb begin
    st_d = st_q;
    guard_d = guard_q;
    unique case (st_q)
      dcps_pkg::IO_IDLE: begin
        if (pass_enable && !host_in) begin
          st_d = dcps_pkg::IO_HOST_LOW;
        end else if (pass_enable && !card_in) begin
          st_d = dcps_pkg::IO_CARD_LOW;
        end
      end
      dcps_pkg::IO_HOST_LOW: begin
        if (host_in || !pass_enable) begin
          st_d = dcps_pkg::IO_GUARD;
          guard_d = dcps_pkg::IO_GUARD_CYCLES;
        end
      end
      dcps_pkg::IO_CARD_LOW: begin
        if (card_in || !pass_enable) begin
          st_d = dcps_pkg::IO_GUARD;
          guard_d = dcps_pkg::IO_GUARD_CYCLES;
        end
      end
      dcps_pkg::IO_GUARD: begin
        // let our own release settle through the synchroniser
        if (guard_q == 2'h0) begin
          st_d = dcps_pkg::IO_IDLE;
        end else begin
          guard_d = guard_q - 2'h1;
        end
      end
    endcase
    // our own forced low on the card wire must not be taken for the card pulling
    if (force_low) begin
      st_d = dcps_pkg::IO_GUARD;
      guard_d = dcps_pkg::IO_GUARD_CYCLES;
    end
    host_pull_d = (st_d == dcps_pkg::IO_CARD_LOW);
    card_pull_d = force_low || (st_d == dcps_pkg::IO_HOST_LOW);
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      st_q <= dcps_pkg::IO_IDLE;
      guard_q <= 2'h0;
      host_pull_q <= 1'b0;
      card_pull_q <= 1'b1;
    end else begin
      st_q <= st_d;
      guard_q <= guard_d;
      host_pull_q <= host_pull_d;
      card_pull_q <= card_pull_d;
    end
  end

  assign host_pull_low = host_pull_q;
  assign card_pull_low = card_pull_q;

endmodule

`default_nettype wire

// ==== src/dcps_top.sv ====
// Purpose: sequencer and router of a dual smart card supply interface
// Assumes: all pin inputs asynchronous to clock; regulators report supply good
// Notes: index 0 of every card vector is card A, index 1 is card B
`timescale 1ns/1ns
`default_nettype none

// Function
// - enable high routes card A or B and 1.8 or 3.0 volt supply.
// - enable low disables both cards and enters shutdown.
// - at most one card interface is active at any time.
// - activation holds reset, clock, data low until supply is nominal.
// - reset and data released about 800 us after supply nominal.
// - card clock enabled on second host clock rising edge after release.
// - deactivation drives card reset low at once.
// - card clock forced low after 2 host clocks, or 8 us.
// - card data forced low about 8 us after enable falls.
// - session ends at once; supply off only after lines forced low.
// - host supply below about 1.0 V acts as enable low.
// - after activation host reset and clock pass to selected card.
// - data line passes both ways, either side may pull low.
module dcps_top #(
  parameter int unsigned RELEASE_CYCLES = dcps_pkg::RELEASE_CYCLES
) (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // host control pins
  input wire logic enable,
  input wire logic card_select,
  input wire logic voltage_select,
  input wire logic host_supply_ok,
  // host signal pins
  input wire logic host_reset_in,
  input wire logic host_clock_in,
  input wire logic host_io_in,
  output logic host_io_out,
  output logic host_io_oe,
  // regulator feedback and control
  input wire logic [1:0] card_supply_good,
  output logic [1:0] card_supply_en,
  output logic [1:0] card_supply_3v0,
  // card pins
  output logic [1:0] card_reset_out,
  output logic [1:0] card_clock_out,
  input wire logic [1:0] card_io_in,
  output logic [1:0] card_io_out,
  output logic [1:0] card_io_oe,
  // status
  output logic shutdown
);

  // last counts of the release hold and of the deactivation timeout
  localparam logic [dcps_pkg::TIMER_W-1:0] REL_LAST =
    dcps_pkg::TIMER_W'(RELEASE_CYCLES - 1);
  localparam logic [dcps_pkg::TIMER_W-1:0] FORCE_LAST =
    dcps_pkg::TIMER_W'(dcps_pkg::FORCE_CYCLES - 1);
  localparam logic [dcps_pkg::TIMER_W-1:0] FORCE_DONE =
    dcps_pkg::TIMER_W'(dcps_pkg::FORCE_CYCLES);

  // ==========================================================
  // input synchronisers
  logic [dcps_pkg::SYNC_W-1:0] pins_s;
  logic run, card_sel_s, volt_sel_s, host_rst_s, host_clk_s, host_io_s;
  logic [1:0] card_io_s, card_good_s;

  // the selects pass the same two flops as enable, so they are latched
  // together with it
  dcps_sync #(
    .WIDTH(dcps_pkg::SYNC_W)
  ) u_sync (
    .clock(clock),
    .reset(reset),
    .async_in({card_supply_good, card_io_in, host_io_in, host_clock_in,
               host_reset_in, host_supply_ok, voltage_select, card_select,
               enable}),
    .sync_out(pins_s)
  );

  // low host supply acts as enable low
  assign run = pins_s[dcps_pkg::SI_ENABLE] && pins_s[dcps_pkg::SI_SUPPLY_OK];
  assign card_sel_s = pins_s[dcps_pkg::SI_CARD_SEL];
  assign volt_sel_s = pins_s[dcps_pkg::SI_VOLT_SEL];
  assign host_rst_s = pins_s[dcps_pkg::SI_HOST_RST];
  assign host_clk_s = pins_s[dcps_pkg::SI_HOST_CLK];
  assign host_io_s = pins_s[dcps_pkg::SI_HOST_IO];
  assign card_io_s = pins_s[dcps_pkg::SI_CARD_IO +: 2];
  assign card_good_s = pins_s[dcps_pkg::SI_CARD_GOOD +: 2];

  // ==========================================================
  // sequencer state
  dcps_pkg::dcps_seq_t st_q, st_d;
  logic [dcps_pkg::TIMER_W-1:0] timer_q, timer_d;
  logic [1:0] edges_q, edges_d;
  logic sel_q, sel_d;
  logic volt_q, volt_d;
  logic clk_off_q, clk_off_d;
  logic clk_prev_q;
  logic host_rise;
  logic clk_forced;
  logic io_pass;

  // card i is the one the sequencer currently serves
  function automatic logic is_live(input logic idx, input logic sel,
                                   input dcps_pkg::dcps_seq_t st);
    is_live = (sel == idx) && (st != dcps_pkg::SEQ_OFF);
  endfunction

  // edges are found on the synchronised copy, so a counted edge lags the pin
  // by two or three core cycles
  assign host_rise = host_clk_s && !clk_prev_q;

  always_comb begin
    st_d = st_q;
    timer_d = timer_q;
    edges_d = edges_q;
    sel_d = sel_q;
    volt_d = volt_q;
    clk_off_d = clk_off_q;
    if (st_q != dcps_pkg::SEQ_OFF && st_q != dcps_pkg::SEQ_DEACT && !run) begin
      st_d = dcps_pkg::SEQ_DEACT;
      timer_d = '0;
      edges_d = 2'h0;
      // a clock already low stays low
      clk_off_d = !card_clock_out[sel_q];
    end else begin
      unique case (st_q)
        dcps_pkg::SEQ_OFF: begin
          if (run) begin
            sel_d = card_sel_s;
            volt_d = volt_sel_s;
            st_d = dcps_pkg::SEQ_RAMP;
          end
        end
        dcps_pkg::SEQ_RAMP: begin
          if (card_good_s[sel_q]) begin
            st_d = dcps_pkg::SEQ_HOLD;
            timer_d = '0;
          end
        end
        dcps_pkg::SEQ_HOLD: begin
          if (timer_q == REL_LAST) begin
            st_d = dcps_pkg::SEQ_CLK_WAIT;
            edges_d = 2'h0;
          end else begin
            timer_d = timer_q + 1'b1;
          end
        end
        dcps_pkg::SEQ_CLK_WAIT: begin
          if (host_rise) begin
            edges_d = edges_q + 2'h1;
            if (edges_q + 2'h1 == dcps_pkg::CLK_EDGES_ON) begin
              st_d = dcps_pkg::SEQ_ACTIVE;
            end
          end
        end
        dcps_pkg::SEQ_ACTIVE: begin
          st_d = dcps_pkg::SEQ_ACTIVE;
        end
        dcps_pkg::SEQ_DEACT: begin
          timer_d = timer_q + 1'b1;
          // count host clock rises until the clock is forced
          if (host_rise && edges_q != dcps_pkg::CLK_EDGES_OFF) begin
            edges_d = edges_q + 2'h1;
          end
          // supply off after all lines forced low
          if (timer_q == FORCE_DONE) begin
            st_d = dcps_pkg::SEQ_OFF;
          end
        end
        default: begin
          st_d = dcps_pkg::SEQ_DEACT;
          timer_d = '0;
          edges_d = 2'h0;
          clk_off_d = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      st_q <= dcps_pkg::SEQ_OFF;
      timer_q <= '0;
      edges_q <= 2'h0;
      sel_q <= 1'b0;
      volt_q <= 1'b0;
      clk_off_q <= 1'b1;
      clk_prev_q <= 1'b0;
    end else begin
      st_q <= st_d;
      timer_q <= timer_d;
      edges_q <= edges_d;
      sel_q <= sel_d;
      volt_q <= volt_d;
      clk_off_q <= clk_off_d;
      clk_prev_q <= host_clk_s;
    end
  end

  // ==========================================================
  // line forcing during deactivation
  // two host clocks or the timeout
  assign clk_forced = clk_off_q || (edges_q == dcps_pkg::CLK_EDGES_OFF) ||
                      (timer_q >= FORCE_LAST);

  // data is bridged from release until the deactivation timeout
  // data forced low at the timeout
  assign io_pass = (st_q == dcps_pkg::SEQ_CLK_WAIT) ||
                   (st_q == dcps_pkg::SEQ_ACTIVE) ||
                   ((st_q == dcps_pkg::SEQ_DEACT) && (timer_q < FORCE_LAST));

  // ==========================================================
  // data line bridge
  logic host_pull, card_pull;

  // while the card wire is forced low the bridge sees our own low on it and
  // masks that echo until the release has passed the synchroniser
  dcps_io_path u_io (
    .clock(clock),
    .reset(reset),
    .pass_enable(io_pass),
    .force_low(!io_pass),
    .host_in(host_io_s),
    .card_in(card_io_s[sel_q]),
    .host_pull_low(host_pull),
    .card_pull_low(card_pull)
  );

  // ==========================================================
  // output registers
  logic [1:0] sup_en_q, sup_en_d;
  logic [1:0] sup_hi_q, sup_hi_d;
  logic [1:0] rst_q, rst_d;
  logic [1:0] clk_q, clk_d;
  logic [1:0] io_oe_q, io_oe_d;
  logic host_oe_q;
  logic shut_q, shut_d;

  always_comb begin
    for (int i = 0; i < 2; i++) begin
      // only the served card is live
      sup_en_d[i] = is_live(1'(i), sel_q, st_q);
      sup_hi_d[i] = is_live(1'(i), sel_q, st_q) && volt_q;
      rst_d[i] = is_live(1'(i), sel_q, st_q) && host_rst_s &&
                 ((st_q == dcps_pkg::SEQ_CLK_WAIT) ||
                  (st_q == dcps_pkg::SEQ_ACTIVE));
      clk_d[i] = is_live(1'(i), sel_q, st_q) && host_clk_s &&
                 ((st_q == dcps_pkg::SEQ_ACTIVE) ||
                  ((st_q == dcps_pkg::SEQ_DEACT) && !clk_forced));
      io_oe_d[i] = is_live(1'(i), sel_q, st_q) ? card_pull : 1'b1;
    end
    // shutdown follows the served supply, so it never shows with a supply on
    shut_d = (st_q == dcps_pkg::SEQ_OFF);
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      sup_en_q <= 2'h0;
      sup_hi_q <= 2'h0;
      rst_q <= 2'h0;
      clk_q <= 2'h0;
      io_oe_q <= 2'h3;
      host_oe_q <= 1'b0;
      shut_q <= 1'b1;
    end else begin
      sup_en_q <= sup_en_d;
      sup_hi_q <= sup_hi_d;
      rst_q <= rst_d;
      clk_q <= clk_d;
      io_oe_q <= io_oe_d;
      host_oe_q <= host_pull;
      shut_q <= shut_d;
    end
  end

  // open drain: data only ever driven low
  assign host_io_out = 1'b0;
  assign host_io_oe = host_oe_q;
  assign card_io_out = 2'h0;
  assign card_io_oe = io_oe_q;
  assign card_supply_en = sup_en_q;
  assign card_supply_3v0 = sup_hi_q;
  assign card_reset_out = rst_q;
  assign card_clock_out = clk_q;
  assign shutdown = shut_q;

endmodule

`default_nettype wire

// ==== verif/dcps_top_asserts.sv ====
// Purpose: port level checks of the dual card power sequencer
// Assumes: bound into dcps_top
// Notes: run is enable qualified by the host supply monitor
`timescale 1ns/1ns
`default_nettype none

module dcps_top_asserts #(
  parameter int unsigned RELEASE_CYCLES = 40000
) (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // host pins
  input wire logic enable,
  input wire logic card_select,
  input wire logic voltage_select,
  input wire logic host_supply_ok,
  input wire logic host_reset_in,
  // card side
  input wire logic [1:0] card_supply_good,
  input wire logic [1:0] card_supply_en,
  input wire logic [1:0] card_supply_3v0,
  input wire logic [1:0] card_reset_out,
  input wire logic [1:0] card_clock_out,
  input wire logic [1:0] card_io_oe,
  input wire logic shutdown
);
  logic run;
  logic [31:0] good_cnt_q;
  logic [31:0] good_cnt_d;

  // ==========================================================
  // cycles since the served supply reported good
  assign run = enable && host_supply_ok;
  always_comb begin
    good_cnt_d = 32'h0;
    if (!reset && (card_supply_en & card_supply_good) != 2'h0) begin
      good_cnt_d = good_cnt_q + 32'h1;
    end
  end
  always_ff @(posedge clock) begin
    good_cnt_q <= good_cnt_d;
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  a_one_card_only: assert property (card_supply_en != 2'h3)
    else $error("both card supplies on");
  a_shutdown_unpowered: assert property (shutdown |-> card_supply_en == 2'h0)
    else $error("supply on in shutdown");
  a_unpowered_lines_low: assert property
    ((~card_supply_en & (card_reset_out | card_clock_out | ~card_io_oe)) == 2'h0)
    else $error("unpowered card line not low");
  a_ramp_lines_low: assert property ((card_supply_en & ~card_supply_good) != 2'h0
    |-> card_reset_out == 2'h0 && card_clock_out == 2'h0 && card_io_oe == 2'h3)
    else $error("line released during ramp");
  a_release_wait: assert property (good_cnt_q != 32'h0 && good_cnt_q < RELEASE_CYCLES
    |-> card_reset_out == 2'h0 && card_io_oe == 2'h3)
    else $error("release too early");
  a_release_done: assert property (good_cnt_q == RELEASE_CYCLES + 10 && host_reset_in
    && run |-> ##[0:4] card_reset_out != 2'h0)
    else $error("release too late");
  a_voltage_route: assert property ($rose(card_supply_en != 2'h0)
    |-> card_supply_en[card_select] && card_supply_3v0[card_select] == voltage_select)
    else $error("wrong card or voltage");
  a_reset_drops: assert property ($fell(run) |-> ##[0:5] card_reset_out == 2'h0)
    else $error("card reset not dropped");
  a_clock_drops: assert property ($fell(run) |-> ##[0:405] card_clock_out == 2'h0)
    else $error("card clock not dropped");
  a_io_forced: assert property ($fell(run) |-> ##[395:410] card_io_oe == 2'h3)
    else $error("card data not forced");
  a_supply_last: assert property ($fell(card_supply_en != 2'h0) |-> $past(card_reset_out)
    == 2'h0 && $past(card_clock_out) == 2'h0 && $past(card_io_oe) == 2'h3)
    else $error("supply off before lines low");
endmodule

bind dcps_top dcps_top_asserts #(.RELEASE_CYCLES(RELEASE_CYCLES)) u_asserts (
  .clock, .reset, .enable, .card_select, .voltage_select, .host_supply_ok,
  .host_reset_in, .card_supply_good, .card_supply_en, .card_supply_3v0,
  .card_reset_out, .card_clock_out, .card_io_oe, .shutdown
);

`default_nettype wire

// ==== verif/dcps_far_model.sv ====
// Purpose: card regulators and pulled up data wires
// Assumes: supply reaches nominal RAMP + 1 cycles after enable
// Notes: wires idle high, any party may pull low
`timescale 1ns/1ns
`default_nettype none

module dcps_far_model #(
  parameter int RAMP = 12
) (
  // clock
  input wire logic clock,
  // regulators
  input wire logic [1:0] card_supply_en,
  output logic [1:0] card_supply_good,
  // data wires
  input wire logic host_io_oe,
  input wire logic host_pull,
  input wire logic [1:0] card_io_oe,
  input wire logic [1:0] card_pull,
  output logic host_io_wire,
  output logic [1:0] card_io_wire
);
  int ramp_q [2];

  // ==========================================================
  // supply ramp, drops at once when disabled
  always_ff @(posedge clock) begin
    for (int i = 0; i < 2; i++) begin
      ramp_q[i] <= card_supply_en[i] ? ramp_q[i] + 1 : 0;
    end
  end
  assign card_supply_good = {ramp_q[1] > RAMP, ramp_q[0] > RAMP};
  assign host_io_wire = !(host_io_oe || host_pull);
  assign card_io_wire = ~(card_io_oe | card_pull);
endmodule

`default_nettype wire

// ==== verif/dual_card_power_sequencer_tb_top.sv ====
// Purpose: self checking bench of the dual card power sequencer
// Assumes: host clock of 160 ns made here, short release hold
// Notes: outputs sampled on the falling clock edge
`timescale 1ns/1ns
`default_nettype none

module dual_card_power_sequencer_tb_top;
  localparam int unsigned REL = 20;
  logic clock, reset, enable, card_select, voltage_select, host_supply_ok;
  logic host_reset_in, host_clock_in, hclk_run, host_pull, cs_q;
  logic host_io_oe, shutdown, host_io_wire, host_io_out;
  logic [1:0] card_pull, card_supply_good, card_supply_en, card_supply_3v0;
  logic [1:0] card_reset_out, card_clock_out, card_io_oe, card_io_wire, card_io_out;
  int fail_count = 0;
  int check_count = 0;
  int cyc = 0;

  dcps_top #(.RELEASE_CYCLES(REL)) dut (
    .clock, .reset, .enable, .card_select, .voltage_select, .host_supply_ok,
    .host_reset_in, .host_clock_in, .host_io_in(host_io_wire), .host_io_out,
    .host_io_oe, .card_supply_good, .card_supply_en, .card_supply_3v0,
    .card_reset_out, .card_clock_out, .card_io_in(card_io_wire), .card_io_out,
    .card_io_oe, .shutdown
  );
  dcps_far_model far (
    .clock, .card_supply_en, .card_supply_good, .host_io_oe, .host_pull,
    .card_io_oe, .card_pull, .host_io_wire, .card_io_wire
  );

  // ==========================================================
  // clocks and watchdog
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  initial begin
    #7;
    forever #80 if (hclk_run) host_clock_in <= ~host_clock_in;
  end
  always @(posedge clock) cyc <= cyc + 1;
  initial begin
    #200000;
    fail_count++;
    tally_and_finish();
  end

  // ==========================================================
  // helpers
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  function automatic logic probe(input int which);
    case (which)
      0: return card_io_oe[cs_q];
      1: return host_io_oe;
      2: return card_clock_out[cs_q];
      3: return card_reset_out[cs_q];
      4: return card_supply_en != 2'h0;
      5: return host_clock_in;
      default: return card_io_oe == 2'h3;
    endcase
  endfunction
  task automatic await(input int which, input logic lvl, input int lim, output int n);
    n = 0;
    while (probe(which) !== lvl && n < lim) begin
      @(negedge clock);
      n++;
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // ==========================================================
  // scenarios
  task automatic t_activate(input logic cs, input logic vs);
    int n;
    int t0;
    @(posedge clock);
    cs_q = cs;
    card_select <= cs;
    voltage_select <= vs;
    hclk_run <= 1'b1;
    enable <= 1'b1;
    await(4, 1'b1, 10, n);
    check("route", {card_supply_en, card_supply_3v0[cs]}, {2'h1 << cs, vs});
    @(posedge clock);
    host_reset_in <= 1'b1;
    t0 = cyc;
    await(0, 1'b0, 200, n);
    check("release_wait", cyc - t0 > REL + 10 && cyc - t0 < REL + 30, 1'b1);
    repeat (4) @(negedge clock);
    check("reset_passed", card_reset_out[cs], 1'b1);
    check("idle_card", {card_reset_out[~cs], card_clock_out[~cs], card_io_oe[~cs],
      card_supply_en[~cs]}, 8'h2);
    await(2, 1'b1, 100, n);
    check("clock_on", n < 60, 1'b1);
    n = 0;
    repeat (64) begin
      @(negedge clock);
      if (card_clock_out[cs] === 1'b1) n++;
    end
    check("clock_passed", n > 24 && n < 40, 1'b1);
    @(posedge clock);
    host_reset_in <= 1'b0;
    repeat (6) @(negedge clock);
    check("warm_reset", card_reset_out[cs], 1'b0);
    @(posedge clock);
    host_reset_in <= 1'b1;
  endtask

  task automatic t_io_bridge();
    int n;
    @(posedge clock);
    host_pull <= 1'b1;
    await(0, 1'b1, 12, n);
    check("card_follows", n < 8, 1'b1);
    check("no_echo", host_io_oe, 1'b0);
    check("drive_low", {host_io_out, card_io_out}, 8'h0);
    @(posedge clock);
    host_pull <= 1'b0;
    await(0, 1'b0, 12, n);
    check("card_freed", n < 10, 1'b1);
    repeat (6) @(posedge clock);
    card_pull[cs_q] <= 1'b1;
    await(1, 1'b1, 12, n);
    check("host_follows", n < 8, 1'b1);
    @(posedge clock);
    card_pull <= 2'h0;
    await(1, 1'b0, 12, n);
    check("host_freed", n < 10, 1'b1);
  endtask

  task automatic t_deact(input logic by_enable, input logic clk_on);
    int n;
    int t0;
    if (!clk_on) begin
      await(5, 1'b1, 20, n);
      hclk_run <= 1'b0;
      await(2, 1'b1, 20, n);
    end
    @(posedge clock);
    t0 = cyc;
    if (by_enable) enable <= 1'b0;
    else host_supply_ok <= 1'b0;
    await(3, 1'b0, 10, n);
    check("reset_drop", n < 8, 1'b1);
    if (clk_on) begin
      repeat (40) @(negedge clock);
      n = 0;
      repeat (24) begin
        @(negedge clock);
        if (card_clock_out[cs_q] !== 1'b0) n++;
      end
      check("clock_drop", n == 0, 1'b1);
    end else begin
      await(2, 1'b0, 450, n);
      check("clock_drop", cyc - t0 > 390, 1'b1);
    end
    await(6, 1'b1, 450, n);
    check("io_forced", cyc - t0 > 390 && cyc - t0 < 410, 1'b1);
    await(4, 1'b0, 30, n);
    check("supply_last", cyc - t0 > 395 && cyc - t0 < 415, 1'b1);
    check("shutdown", shutdown, 1'b1);
    @(posedge clock);
    enable <= 1'b0;
    host_supply_ok <= 1'b1;
    host_reset_in <= 1'b0;
    hclk_run <= 1'b0;
  endtask

  task automatic t_idle_selects();
    for (int k = 0; k < 4; k++) begin
      @(posedge clock);
      card_select <= k[1];
      voltage_select <= k[0];
      repeat (6) @(negedge clock);
      check("idle_off", {shutdown, card_supply_en}, 8'h4);
    end
  endtask

  // ==========================================================
  // main sequence
  initial begin
    reset = 1'b1;
    enable = 1'b0;
    card_select = 1'b0;
    voltage_select = 1'b0;
    host_supply_ok = 1'b1;
    host_reset_in = 1'b0;
    host_clock_in = 1'b0;
    hclk_run = 1'b0;
    host_pull = 1'b0;
    card_pull = 2'h0;
    cs_q = 1'b0;
    repeat (4) @(posedge clock);
    reset <= 1'b0;
    @(negedge clock);
    check("reset_state", {shutdown, card_supply_en, card_io_oe, host_io_oe,
      card_reset_out}, 8'h98);
    for (int k = 0; k < 4; k++) begin
      t_activate(k[1], k[0]);
      t_io_bridge();
      t_deact(k != 3, k != 1);
    end
    t_idle_selects();
    tally_and_finish();
  end
endmodule

`default_nettype wire
